// ### igc_pkg.sv
// igc_pkg: constants and types for the if gain control loop.
// assumes a 10-bit two's complement adc sample stream on core_clk_i.
//
// Contract
// - Each sample's absolute value is compared with a programmable target to form an error.
// - The error is loop filtered and the filter output is the gain control value.
// - The control value leaves as a one-bit sigma-delta stream on the primary pin.
// - Per-loop slope polarity bits exist and software sets them to match each amplifier.
// - A wide loop bandwidth is used while acquiring and a narrow one once tracking.
// - The loop keeps running across channel changes and is never halted by them.
// - After a channel change the loop reconverges at once, not waiting for tuner lock.
// - A lock indication is given and downstream acquisition is held until it is set.
package igc_pkg;
   localparam int SAMPLE_W      = 10;
   localparam int ERR_W         = 11;
   localparam int ACC_W         = 20;
   localparam int CTRL_W        = 12;
   localparam int UPD_DIV       = 64;
   localparam int DIV_W         = 6;
   localparam int ACQ_SHIFT     = 4;
   localparam int TRK_SHIFT     = 0;
   localparam int LOCK_RUN      = 16;
   localparam int RUN_W         = 5;
   localparam int LOCK_WIN      = 8;
   localparam logic [SAMPLE_W-2:0] TARGET_DEFAULT = 9'h0_0B4;
   localparam logic [ACC_W-1:0]    ACC_RESET      = 20'h8_0000;

   typedef enum logic [1:0] {
      IGC_ACQ   = 2'b00,
      IGC_TRACK = 2'b01
   } igc_mode_t;
endpackage

// ### igc_sd_if.sv
// igc_sd_if: carries a control word to a sigma-delta stage and its bit back.
// assumes both ends on core_clk_i.
`timescale 1ns/1ps
interface igc_sd_if;
   import igc_pkg::*;
   logic [CTRL_W-1:0] level;
   logic              bit_out;
   modport src (output level, input bit_out);
   modport mod (input level, output bit_out);
endinterface

// ### igc_sd_mod.sv
// igc_sd_mod: first order sigma-delta modulator, one bit per clock.
// assumes level changes at any time; the carry is the output density.
`timescale 1ns/1ps
module igc_sd_mod
   import igc_pkg::*;
(
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   // word in, bit out
   igc_sd_if.mod     sd
);
   typedef struct packed {
      logic [CTRL_W-1:0] acc;
      logic              bit_q;
   } igc_sd_st_t;

   igc_sd_st_t st;
   igc_sd_st_t next_st;
   logic [CTRL_W:0] sum;

   always_comb begin
      next_st = st;
      sum = {1'b0, st.acc} + {1'b0, sd.level};
      next_st.acc = sum[CTRL_W-1:0];
      next_st.bit_q = sum[CTRL_W];
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sd.bit_out = st.bit_q;
endmodule

// ### igc_top.sv
// igc_top: digital gain loop measuring adc magnitude, driving amplifiers.
// assumes adc samples synchronous to core_clk_i with a valid strobe, and
// an external rc low-pass on each gain output.
`timescale 1ns/1ps
module igc_top
   import igc_pkg::*;
(
   // clock and reset
   input  wire logic                core_clk_i,
   input  wire logic                rst_i,
   // samples
   input  wire logic [SAMPLE_W-1:0] sample_i,
   input  wire logic                sample_vld_i,
   // configuration
   input  wire logic [SAMPLE_W-2:0] target_i,
   input  wire logic                slope_inv1_i,
   input  wire logic                slope_inv2_i,
   input  wire logic                sec_gpio_mode_i,
   input  wire logic                sec_gpio_out_i,
   input  wire logic                sec_gpio_oe_i,
   input  wire logic                channel_change_i,
   // gain pins
   output logic                     primary_gain_ctrl_out_o,
   output logic                     primary_gain_ctrl_out_oe_o,
   output logic                     secondary_gain_ctrl_or_gpio_o,
   output logic                     secondary_gain_ctrl_or_gpio_oe_o,
   // status
   output logic                     gain_lock_o,
   output logic                     acq_hold_o,
   output logic [CTRL_W-1:0]        gain_level_o
);
   typedef struct packed {
      logic [ERR_W-1:0]  err_sum;
      logic [DIV_W-1:0]  div;
      logic [ACC_W-1:0]  acc;
      logic [RUN_W-1:0]  run;
      igc_mode_t         mode;
      logic              lock;
      logic              hold;
      logic              p_bit;
      logic              p_oe;
      logic              s_bit;
      logic              s_oe;
   } igc_st_t;

   igc_st_t st;
   igc_st_t next_st;

   igc_sd_if sd1 ();
   igc_sd_if sd2 ();

   logic [SAMPLE_W-2:0] mag;
   logic signed [ERR_W-1:0] err;
   logic signed [ACC_W-1:0] step;
   logic signed [ACC_W:0]   acc_s;
   logic [ACC_W-1:0]        acc_n;
   logic                    upd;
   logic                    in_win;

   ////////////////////////////////////////////////////////////////////////
   // magnitude against target; most negative code saturates
   always_comb begin
      if (sample_i == {1'b1, {(SAMPLE_W-1){1'b0}}}) begin
         mag = '1;
      end else if (sample_i[SAMPLE_W-1]) begin
         mag = (SAMPLE_W-1)'(-sample_i);
      end else begin
         mag = sample_i[SAMPLE_W-2:0];
      end
      err = $signed({2'b00, target_i}) - $signed({2'b00, mag});
   end

   assign upd = (st.div == DIV_W'(UPD_DIV - 1));
   assign step = (st.mode == IGC_ACQ) ?
                 (ACC_W'($signed(st.err_sum)) <<< ACQ_SHIFT) :
                 (ACC_W'($signed(st.err_sum)) <<< TRK_SHIFT);
   // one guard bit shows both overflow and underflow of the integrator
   assign acc_s = $signed({1'b0, st.acc}) + $signed({step[ACC_W-1], step});
   assign in_win = ($signed(st.err_sum) < $signed(ERR_W'(LOCK_WIN))) &&
                   ($signed(st.err_sum) > -$signed(ERR_W'(LOCK_WIN)));

   // saturate the integrator so the control word cannot wrap
   always_comb begin
      if (acc_s[ACC_W] && !step[ACC_W-1]) begin
         acc_n = '1;
      end else if (acc_s[ACC_W]) begin
         acc_n = '0;
      end else begin
         acc_n = acc_s[ACC_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      next_st.div = st.div + DIV_W'(1);
      if (sample_vld_i) begin
         // running average error, cleared only by reset: three quarters of the old value plus a quarter of each sample error
         next_st.err_sum = ERR_W'(($signed(st.err_sum) * 3 + err) >>> 2);
      end
      if (upd) begin
         next_st.acc = acc_n;
         if (in_win) begin
            if (st.run != RUN_W'(LOCK_RUN)) begin
               next_st.run = st.run + RUN_W'(1);
            end
         end else begin
            next_st.run = '0;
         end
         next_st.lock = in_win &&
                        (st.run >= RUN_W'(LOCK_RUN - 1));
         next_st.mode = next_st.lock ? IGC_TRACK : IGC_ACQ;
      end
      // channel change reopens bandwidth, loop keeps running
      if (channel_change_i) begin
         next_st.mode = IGC_ACQ;
         next_st.run = '0;
         next_st.lock = 1'b0;
      end
      next_st.hold = ~next_st.lock;
      // open drain primary: drive low only
      next_st.p_bit = 1'b0;
      next_st.p_oe = ~sd1.bit_out;
      // gpio mode takes over secondary pin
      if (sec_gpio_mode_i) begin
         next_st.s_bit = sec_gpio_out_i;
         next_st.s_oe = sec_gpio_oe_i;
      end else begin
         next_st.s_bit = sd2.bit_out;
         next_st.s_oe = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '{err_sum: '0, div: '0, acc: ACC_RESET, run: '0,
                 mode: IGC_ACQ, lock: 1'b0, hold: 1'b1, p_bit: 1'b0,
                 p_oe: 1'b0, s_bit: 1'b0, s_oe: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign sd1.level = slope_inv1_i ? ~st.acc[ACC_W-1 -: CTRL_W] :
                      st.acc[ACC_W-1 -: CTRL_W];
   assign sd2.level = slope_inv2_i ? ~st.acc[ACC_W-1 -: CTRL_W] :
                      st.acc[ACC_W-1 -: CTRL_W];

   igc_sd_mod u_sd1 (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .sd         (sd1)
   );

   igc_sd_mod u_sd2 (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .sd         (sd2)
   );

   assign primary_gain_ctrl_out_o          = st.p_bit;
   assign primary_gain_ctrl_out_oe_o       = st.p_oe;
   assign secondary_gain_ctrl_or_gpio_o    = st.s_bit;
   assign secondary_gain_ctrl_or_gpio_oe_o = st.s_oe;
   assign gain_lock_o  = st.lock;
   assign acq_hold_o   = st.hold;
   assign gain_level_o = st.acc[ACC_W-1 -: CTRL_W];

   ////////////////////////////////////////////////////////////////////////
   property p_hold_tracks_lock;
      @(posedge core_clk_i) disable iff (rst_i)
      acq_hold_o == ~gain_lock_o;
   endproperty
   a_hold_tracks_lock: assert property (p_hold_tracks_lock)
      else $error("hold not inverse of lock");

   property p_lock_drops;
      @(posedge core_clk_i) disable iff (rst_i)
      channel_change_i |=> !gain_lock_o && st.mode == IGC_ACQ;
   endproperty
   a_lock_drops: assert property (p_lock_drops)
      else $error("channel change did not reopen loop");

   property p_gpio_owns;
      @(posedge core_clk_i) disable iff (rst_i)
      sec_gpio_mode_i |=> secondary_gain_ctrl_or_gpio_oe_o ==
                          $past(sec_gpio_oe_i);
   endproperty
   a_gpio_owns: assert property (p_gpio_owns)
      else $error("secondary stream driven in gpio mode");

   property p_mode_lock;
      @(posedge core_clk_i) disable iff (rst_i)
      gain_lock_o |-> st.mode == IGC_TRACK;
   endproperty
   a_mode_lock: assert property (p_mode_lock)
      else $error("tracking bandwidth not used while locked");

   property p_pri_stream;
      @(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> !primary_gain_ctrl_out_o &&
               primary_gain_ctrl_out_oe_o == ~$past(sd1.bit_out);
   endproperty
   a_pri_stream: assert property (p_pri_stream)
      else $error("primary pin does not follow the stream");

   property p_sec_stream;
      @(posedge core_clk_i) disable iff (rst_i)
      !sec_gpio_mode_i |=> secondary_gain_ctrl_or_gpio_oe_o &&
                           secondary_gain_ctrl_or_gpio_o == $past(sd2.bit_out);
   endproperty
   a_sec_stream: assert property (p_sec_stream)
      else $error("secondary pin does not follow its stream");

   property p_lock_run;
      @(posedge core_clk_i) disable iff (rst_i)
      $rose(gain_lock_o) |-> st.run == RUN_W'(LOCK_RUN);
   endproperty
   a_lock_run: assert property (p_lock_run)
      else $error("lock set before a full in-window run");

   property p_lock_leave;
      @(posedge core_clk_i) disable iff (rst_i)
      upd && gain_lock_o && !in_win |=> !gain_lock_o;
   endproperty
   a_lock_leave: assert property (p_lock_leave)
      else $error("lock kept after error left the window");
endmodule

// ### igc_amp_model.sv
// igc_amp_model: rc low-pass and gain amplifier behind the primary pin.
// assumes an open-drain pin with pull-up and a sample clock shared with dut.
`timescale 1ns/1ps
module igc_amp_model (
   // clock
   input  wire logic       core_clk_i,
   // gain pin and amplifier setup
   input  wire logic       pin_oe_i,
   input  wire logic       neg_slope_i,
   input  wire logic [9:0] src_amp_i,
   // adc side
   output logic [9:0]      sample_o,
   output logic            sample_vld_o
);
   int filt = 2048;
   int g;
   int a;
   // pull-up gives the level while the pin is released
   wire pin = ~pin_oe_i;
   always @(posedge core_clk_i) begin
      // rc low-pass, slow against the update rate to keep ripple small
      filt <= filt + (((pin ? 4095 : 0) - filt) >>> 8);
      g = neg_slope_i ? 4095 - filt : filt;
      // steady envelope with a little jitter, random sign
      a = ((int'(src_amp_i) * g) >>> 11) + int'($urandom % 5) - 2;
      if (a > 511) a = 511;
      if (a < 0) a = 0;
      sample_o <= #2 ($urandom % 2) ? 10'(-a) : 10'(a);
      sample_vld_o <= #2 ($urandom % 8) != 0;
   end
endmodule

// ### tb.sv
// tb: closed-loop bench for igc_top with an amplifier model.
// assumes igc_pkg constants; the loop needs many 64-clock updates to lock.
`timescale 1ns/1ps
module tb;
   import igc_pkg::*;
   logic                core_clk_i = 0;
   logic                rst_i = 1;
   logic [SAMPLE_W-1:0] smp;
   logic                vld;
   logic [SAMPLE_W-2:0] target = TARGET_DEFAULT;
   logic                slope = 0, gmode = 0, gout = 0, goe = 0, cc = 0;
   logic                slope2 = 0;
   logic [9:0]          amp = 10'h0_0C8;
   logic                p_o, p_oe, s_o, s_oe, lock, hold;
   logic [CTRL_W-1:0]   lvl;
   int                  fails = 0, check_count = 0, n, sum, e, lv0, cnt2;
   always #10 core_clk_i = ~core_clk_i;
   igc_top DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .sample_i(smp),
      .sample_vld_i(vld), .target_i(target), .slope_inv1_i(slope),
      .slope_inv2_i(slope2), .sec_gpio_mode_i(gmode), .sec_gpio_out_i(gout),
      .sec_gpio_oe_i(goe), .channel_change_i(cc),
      .primary_gain_ctrl_out_o(p_o), .primary_gain_ctrl_out_oe_o(p_oe),
      .secondary_gain_ctrl_or_gpio_o(s_o),
      .secondary_gain_ctrl_or_gpio_oe_o(s_oe), .gain_lock_o(lock),
      .acq_hold_o(hold), .gain_level_o(lvl));
   igc_amp_model amp_model (.core_clk_i(core_clk_i), .pin_oe_i(p_oe),
      .neg_slope_i(slope), .src_amp_i(amp), .sample_o(smp),
      .sample_vld_o(vld));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic near(input int v, input int x, input int tol);
      return (v >= x - tol) && (v <= x + tol);
   endfunction
   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         fails++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk_i);
      #2;
   endtask
   // bounded: a stuck loop must not hang the run
   task automatic wait_lock();
      n = 0;
      while (lock !== 1'b1 && n < 30000) begin
         tick(1);
         n++;
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h8d6a));
      slope2 = 1'($urandom % 2);
      tick(11);
      chk(hold === 1'b1 && lock === 1'b0 && lvl === 12'h0800, "reset");
      chk({p_o, p_oe, s_o, s_oe} === 4'h0, "reset pins");
      tick(1);
      rst_i = 0;
      wait_lock();
      chk(lock === 1'b1, "no lock");
      chk(hold === ~lock, "hold");
      e = (int'(lvl) * 2048) >>> 12;
      n = slope2 ? ((4095 - int'(lvl)) * 2048) >>> 12 : e;
      sum = 0;
      cnt2 = 0;
      for (int i = 0; i < 2048; i++) begin
         tick(1);
         sum += int'(!p_oe);
         cnt2 += int'(s_o === 1'b1 && s_oe === 1'b1);
      end
      chk(near(sum, e, 64) && p_o === 1'b0, "stream density");
      chk(near(cnt2, n, 64), "secondary density");
      lv0 = int'(lvl);
      cc = 1;
      amp = 10'h0_168;
      slope = 1;
      target = 9'h0_0A0;
      tick(1);
      cc = 0;
      chk(lock === 1'b0 && hold === 1'b1, "lock kept");
      chk(near(int'(lvl), lv0, 16) && lvl !== 12'h0800, "loop reset");
      wait_lock();
      chk(lock === 1'b1, "no relock");
      sum = 0;
      n = 0;
      // samples are read at the edge, where the design takes them
      while (n < 1024) begin
         @(posedge core_clk_i);
         if (vld === 1'b1) begin
            sum += smp[9] ? 1024 - int'(smp) : int'(smp);
            n++;
         end
      end
      tick(1);
      chk(near(sum / 1024, 160, 24), "magnitude");
      gmode = 1;
      for (int i = 0; i < 8; i++) begin
         gout = 1'($urandom % 2);
         goe = 1'($urandom % 2);
         tick(2);
         chk(s_o === gout && s_oe === goe, "gpio");
      end
      // a target step leaves the window without any channel change
      gmode = 0;
      target = 9'h0_0C8;
      tick(4 * UPD_DIV);
      chk(lock === 1'b0 && hold === 1'b1, "lock off window");
      give_verdict();
   end
   initial begin
      #(80000 * 20);
      fails++;
      give_verdict();
   end
endmodule
